// [p8t_core.sv]
// issue and cycle accounting for a pipelined 8051 core
// assumes opcodes arrive from program memory logic on i_mclk with a valid/ready handshake,
// and that the branch outcome is presented together with the branch opcode
`timescale 1ns/1ns
`include "p8t_cfg.svh"

// Notes on behaviour
// - every opcode is decoded to its standard 8051 length and a timing class.
// - timing is counted in single clock cycles with no machine cycle.
// - most instructions take one or two clocks and none takes more than eight.
// - the instruction set holds 109 instructions spread over one to eight clocks.
// - a plain instruction takes as many clocks as it has program bytes.
// - a conditional branch not taken finishes one clock sooner than when taken.
// - the core runs at clock rates up to 24 MHz for 24 MIPS peak.
// - add and add with carry take one byte for register and indirect, two otherwise.
// - subtract with borrow uses the same byte counts as add.
module p8t_core
  import p8t_pkg::*;
#(
  parameter p8t_pkg::p8t_cyc_t MUL_CYC = `P8T_MUL_CYC,
  parameter p8t_pkg::p8t_cyc_t DIV_CYC = `P8T_DIV_CYC
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // opcode fetch
  input wire logic i_op_valid,
  input wire logic [7:0] i_op_byte,
  input wire logic i_br_taken,
  output logic o_op_ready,
  // issue report
  output logic o_issue,
  output p8t_pkg::p8t_len_t o_bytes,
  output p8t_pkg::p8t_cyc_t o_cycles,
  output logic o_retire
);
  import p8t_pkg::*;

  p8t_len_t dec_len;
  p8t_cls_t dec_cls;
  p8t_cyc_t next_cycles;
  p8t_cyc_t remain;
  logic accept;

  p8t_opc_class u_class
  (
    .i_opcode(i_op_byte),
    .o_len(dec_len),
    .o_cls(dec_cls)
  );

  // plain cycles come from bytes, so a 24 MHz clock gives 24 MIPS on one-byte plain code
  always_comb
  begin
    next_cycles = {2'h0, dec_len};
    unique case (dec_cls)
      P8T_CLS_PLAIN:
        next_cycles = {2'h0, dec_len};
      P8T_CLS_BRANCH:
      begin
        // the outcome rides with the opcode, so the extra clock is known at issue
        if (i_br_taken)
        begin
          next_cycles = 4'({2'h0, dec_len} + `P8T_TAKEN_EXTRA);
        end
        else
        begin
          next_cycles = {2'h0, dec_len};
        end
      end
      P8T_CLS_IND_ARITH:
        next_cycles = 4'({2'h0, dec_len} + `P8T_IND_EXTRA);
      P8T_CLS_MUL:
        next_cycles = MUL_CYC;
      P8T_CLS_DIV:
        next_cycles = DIV_CYC;
    endcase
    if (next_cycles > `P8T_MAX_CYC)
    begin
      next_cycles = `P8T_MAX_CYC;
    end
  end

  // the last cycle of an instruction overlaps the next fetch
  assign o_op_ready = (remain <= `P8T_MIN_CYC);
  assign accept = i_op_valid && o_op_ready;
  assign o_retire = (remain == `P8T_MIN_CYC);

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      remain <= 4'h0;
    end
    else if (accept)
    begin
      remain <= next_cycles;
    end
    else if (remain != 4'h0)
    begin
      remain <= remain - 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_issue <= 1'b0;
      o_bytes <= 2'h0;
      o_cycles <= 4'h0;
    end
    else
    begin
      o_issue <= accept;
      if (accept)
      begin
        o_bytes <= dec_len;
        o_cycles <= next_cycles;
      end
    end
  end

  // helper state for the timing checks below; the issue logic never reads it
  p8t_cyc_t age;
  p8t_cls_t run_cls;
  logic run_tkn;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      age <= 4'h0;
    end
    else if (accept)
    begin
      age <= 4'h1;
    end
    else if (age != 4'h0 && age != 4'hf)
    begin
      age <= age + 4'h1; // saturates so a long idle spell cannot wrap back into range
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      run_cls <= P8T_CLS_PLAIN;
      run_tkn <= 1'b0;
    end
    else if (accept)
    begin
      run_cls <= dec_cls;
      run_tkn <= i_br_taken;
    end
  end

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_STALL: assert property (o_issue && o_cycles > 4'h1 |-> !o_op_ready)
    else $error("opcode accepted while instruction unfinished");
  AST_PLAIN_EQ_BYTES: assert property (accept && dec_cls == P8T_CLS_PLAIN |=> o_cycles == {2'h0, o_bytes})
    else $error("plain instruction cycles differ from bytes");
  AST_BR_TAKEN: assert property (accept && dec_cls == P8T_CLS_BRANCH && i_br_taken
    |=> o_cycles == 4'({2'h0, o_bytes} + 4'h1))
    else $error("taken branch not one cycle longer");
  AST_BR_NOT: assert property (accept && dec_cls == P8T_CLS_BRANCH && !i_br_taken |=> o_cycles == {2'h0, o_bytes})
    else $error("untaken branch not equal to bytes");
  AST_MAX: assert property (o_issue |-> o_cycles >= 4'h1 && o_cycles <= 4'h8)
    else $error("instruction cycles out of range");
  AST_ONE_CYC: assert property (accept && next_cycles == 4'h1 |=> o_retire && o_op_ready)
    else $error("single cycle instruction did not retire");
  AST_TWO_CYC: assert property (accept && next_cycles == 4'h2 |=> !o_op_ready ##1 o_retire)
    else $error("two cycle instruction mistimed");
  AST_ADD_SHORT: assert property (accept
    && (i_op_byte[7:3] == 5'b0010_1 || i_op_byte[7:1] == 7'b0010_011
    || i_op_byte[7:3] == 5'b1001_1 || i_op_byte[7:1] == 7'b1001_011) |=> o_bytes == 2'h1)
    else $error("register or indirect add length wrong");
  AST_ADD_LONG: assert property (accept
    && (i_op_byte == 8'h24 || i_op_byte == 8'h25 || i_op_byte == 8'h34
    || i_op_byte == 8'h35 || i_op_byte == 8'h94 || i_op_byte == 8'h95) |=> o_bytes == 2'h2)
    else $error("direct or immediate add length wrong");
  AST_DIV: assert property (accept && i_op_byte == 8'h84 |=> !o_retire [*7] ##1 o_retire)
    else $error("divide not eight cycles");
  AST_NO_OVERTAKE: assert property (age != 4'h0 && age < o_cycles |-> !o_op_ready)
    else $error("ready raised before the current instruction ends");
  AST_ISSUE_ONCE: assert property (o_issue && o_cycles > 4'h1 |=> !o_issue)
    else $error("second opcode issued behind a multi clock instruction");
  AST_RETIRE_AT: assert property (o_retire |-> age == o_cycles)
    else $error("retire not on the counted clock");
  AST_RETIRE_ONCE: assert property (o_retire && !accept |=> !o_retire)
    else $error("instruction retired twice");
  AST_PEAK: assert property (o_issue && o_cycles == 4'h1 |-> o_op_ready && o_retire)
    else $error("one clock instruction blocks the next fetch");
  AST_RETIRE_PLAIN: assert property (o_retire && run_cls == P8T_CLS_PLAIN |-> age == {2'h0, o_bytes})
    else $error("plain instruction did not retire after its byte count");
  AST_RETIRE_BR: assert property (o_retire && run_cls == P8T_CLS_BRANCH
    |-> age == 4'({2'h0, o_bytes} + {3'h0, run_tkn}))
    else $error("branch retire clock wrong");
  AST_RETIRE_DIV: assert property (o_retire && run_cls == P8T_CLS_DIV |-> age == 4'h8)
    else $error("divide did not retire on its eighth clock");
  AST_IND_ARITH: assert property (accept && dec_cls == P8T_CLS_IND_ARITH
    |=> o_bytes == 2'h1 && o_cycles == 4'h2)
    else $error("indirect arithmetic timing wrong");
  AST_ADDC_SHORT: assert property (accept
    && (i_op_byte[7:3] == 5'b0011_1 || i_op_byte[7:1] == 7'b0011_011) |=> o_bytes == 2'h1)
    else $error("register or indirect add with carry length wrong");
  AST_MUL: assert property (accept && i_op_byte == 8'ha4
    |=> o_bytes == 2'h1 && o_cycles == MUL_CYC)
    else $error("multiply timing wrong");
  AST_AJMP: assert property (accept && i_op_byte[3:0] == 4'h1 |=> o_bytes == 2'h2)
    else $error("absolute jump or call length wrong");
  AST_LONG_JUMP: assert property (accept && (i_op_byte == 8'h02 || i_op_byte == 8'h12)
    |=> o_bytes == 2'h3)
    else $error("long jump or call length wrong");
  AST_BYTES_RANGE: assert property (o_issue |-> o_bytes != 2'h0)
    else $error("issued instruction has no length");

  COV_BACK2BACK: cover property (accept ##1 accept ##1 accept);
  COV_BR_TAKEN: cover property (accept && dec_cls == P8T_CLS_BRANCH && i_br_taken);
  COV_STALL: cover property (i_op_valid && !o_op_ready);
  COV_MUL: cover property (accept && dec_cls == P8T_CLS_MUL);
  COV_BR_NOT: cover property (accept && dec_cls == P8T_CLS_BRANCH && !i_br_taken);
endmodule

// [p8t_cfg.svh]
// timing constants of the pipelined 8051 instruction timing block
// assumes inclusion by bare name from the design modules
`ifndef P8T_CFG_SVH
`define P8T_CFG_SVH
`define P8T_MAX_CYC 4'h8
`define P8T_MIN_CYC 4'h1
`define P8T_MUL_CYC 4'h4
`define P8T_DIV_CYC 4'h8
`define P8T_IND_EXTRA 4'h1
`define P8T_TAKEN_EXTRA 4'h1
`define P8T_PEAK_MHZ 24
`endif

// [p8t_pkg.sv]
// types shared by the instruction timing modules
// assumes nothing of its surroundings
package p8t_pkg;
  typedef logic [1:0] p8t_len_t;
  typedef logic [3:0] p8t_cyc_t;
  typedef enum logic [2:0] {
    P8T_CLS_PLAIN,
    P8T_CLS_BRANCH,
    P8T_CLS_IND_ARITH,
    P8T_CLS_MUL,
    P8T_CLS_DIV
  } p8t_cls_t;
endpackage

// [p8t_opc_class.sv]
// opcode length and timing class lookup
// assumes a standard 8051 opcode byte at its input; purely combinational
`timescale 1ns/1ns
module p8t_opc_class
  import p8t_pkg::*;
(
  // opcode
  input wire logic [7:0] i_opcode,
  // decode
  output p8t_pkg::p8t_len_t o_len,
  output p8t_pkg::p8t_cls_t o_cls
);
  always_comb
  begin
    o_len = 2'h1;
    casez (i_opcode)
      8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90, 8'hb4, 8'hb5,
      8'hb6, 8'hb7, 8'b1011_1???, 8'hd5:
        o_len = 2'h3;
      8'b????_0001, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h24, 8'h25, 8'h34, 8'h35, 8'h44, 8'h45,
      8'h54, 8'h55, 8'h64, 8'h65, 8'h72, 8'h74, 8'h76, 8'h77, 8'b0111_1???, 8'h82, 8'h86, 8'h87,
      8'b1000_1???, 8'h92, 8'h94, 8'h95, 8'ha0, 8'ha2, 8'ha6, 8'ha7, 8'b1010_1???, 8'hb0, 8'hb2,
      8'hc0, 8'hc2, 8'hc5, 8'hd0, 8'hd2, 8'b1101_1???, 8'he5, 8'hf5, 8'h05, 8'h15, 8'h42, 8'h52,
      8'h62:
        o_len = 2'h2;
      default:
        o_len = 2'h1;
    endcase
  end

  always_comb
  begin
    o_cls = P8T_CLS_PLAIN;
    casez (i_opcode)
      8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'b1011_01??, 8'b1011_1???, 8'hd5,
      8'b1101_1???:
        o_cls = P8T_CLS_BRANCH;
      8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97:
        o_cls = P8T_CLS_IND_ARITH;
      8'ha4:
        o_cls = P8T_CLS_MUL;
      8'h84:
        o_cls = P8T_CLS_DIV;
      default:
        o_cls = P8T_CLS_PLAIN;
    endcase
  end
endmodule

// [p8t_pmem.sv]
// program memory model offering opcode bytes to the core
// assumes the bench raises i_req with a byte and drops it once o_done shows
`timescale 1ns/1ns
module p8t_pmem
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // bench side
  input wire logic i_req,
  input wire logic [7:0] i_byte,
  input wire logic i_tkn,
  output logic o_done,
  // core side
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_tkn
);
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
      o_done <= 1'b0;
    else
      o_done <= o_valid && i_ready;
  // idle lines toggle so a stale byte never passes for a fresh one
  always_ff @(negedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_valid <= 1'b0;
      o_byte <= 8'hff;
      o_tkn <= 1'b0;
    end
    else if (!o_valid || o_done)
    begin
      o_valid <= i_req;
      o_byte <= i_req ? i_byte : ~o_byte;
      o_tkn <= i_req ? i_tkn : ~o_tkn;
    end
endmodule

// [p8t_core_bench.sv]
// self-checking bench for the instruction timing core
// assumes the program memory model in p8t_pmem drives the fetch port
`timescale 1ns/1ns
`include "p8t_cfg.svh"
module p8t_core_bench;
  import p8t_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, i_op_valid, i_br_taken, o_op_ready, o_issue, o_retire, done;
  logic req = 0, tkq = 0;
  logic [7:0] i_op_byte, opq = 8'h00;
  p8t_len_t o_bytes;
  p8t_cyc_t o_cycles;
  int fail_count = 0, checks = 0;
  always #2 i_mclk = ~i_mclk;
  p8t_pmem pm (.i_mclk, .i_rst_n, .i_req(req), .i_byte(opq), .i_tkn(tkq), .o_done(done),
    .i_ready(o_op_ready), .o_valid(i_op_valid), .o_byte(i_op_byte), .o_tkn(i_br_taken));
  p8t_core dut (.i_mclk, .i_rst_n, .i_op_valid, .i_op_byte, .i_br_taken, .o_op_ready,
    .o_issue, .o_bytes, .o_cycles, .o_retire);
  task finish_test;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wait_take(input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    while (!done && n < lim);
    if (!done)
    begin
      fail_count++;
      finish_test;
    end
  endtask
  // offer one opcode, then time its issue and retire
  task send(input logic [7:0] op, input logic tk, input logic [1:0] eb, input logic [3:0] ec);
    int n;
    req = 1;
    opq = op;
    tkq = tk;
    wait_take(40, n);
    req = 0;
    chk("issue", o_issue, 1);
    chk("bytes", o_bytes, eb);
    chk("cycles", o_cycles, ec);
    n = 1;
    while (!o_retire && n < 12)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("retire_at", n[7:0], ec);
  endtask
  // every add, addc and subb form; rn is one clock, at-ri costs one extra
  task t_arith;
    logic [7:0] b[3] = '{8'h20, 8'h30, 8'h90};
    logic [3:0] l[6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
    foreach (b[i])
      foreach (l[j])
        send(b[i] | l[j], 0, (l[j] < 6) ? 2'd2 : 2'd1, (l[j] > 7) ? 4'h1 : 4'h2);
  endtask
  // not taken finishes one clock before taken, back to back
  task t_branch;
    send(8'h60, 0, 2'd2, 4'h2);
    send(8'h60, 1, 2'd2, 4'h3);
    send(8'hb4, 0, 2'd3, 4'h3);
    send(8'hb4, 1, 2'd3, 4'h4);
    send(8'hd8, 1, 2'd2, 4'h3);
  endtask
  task t_long;
    send(8'ha4, 0, 2'd1, `P8T_MUL_CYC);
    send(8'h84, 0, 2'd1, 4'h8);
    send(8'h02, 0, 2'd3, 4'h3);
    send(8'h01, 0, 2'd2, 4'h2);
  endtask
  // a second opcode offered behind a divide waits all eight clocks
  task t_stall;
    int n;
    req = 1;
    opq = 8'h84;
    wait_take(40, n);
    opq = 8'h04;
    wait_take(20, n);
    req = 0;
    chk("stall", n[7:0], 8);
    chk("cycles", o_cycles, 1);
    repeat (3) @(posedge i_mclk);
  endtask
  initial
  begin
    repeat (5) @(posedge i_mclk);
    chk("rst_out", {o_issue, o_retire, o_bytes, o_cycles}, 8'h00);
    chk("rst_ready", o_op_ready, 1);
    @(negedge i_mclk);
    i_rst_n = 1;
    // first offer one edge later, clear of the model's reset branch
    @(posedge i_mclk);
    t_arith;
    t_branch;
    t_long;
    t_stall;
    finish_test;
  end
endmodule
